// File: shared/gpd_pkg.sv
// Constants shared by the general-purpose port data block.
// Assumes a 32-bit AHB-Lite bus and byte-wide ports A, B and C.
package gpd_pkg;

  localparam int NPORT = 3;
  localparam int PW    = 8;
  localparam int FW    = 16;
  localparam int IDXW  = 30;
  localparam int ALSB  = 2;

  // Printed offsets are indexes; byte address is four times the index
  localparam logic [2:0][31:0] DATA_IDX     = {32'h0400_0124, 32'h0400_0122,
                                               32'h0400_0120};
  localparam logic [2:0][31:0] DATA_ALT_IDX = {32'hA400_0124, 32'hA400_0122,
                                               32'hA400_0120};
  // Function control words, byte addresses
  localparam logic [2:0][31:0] FC_ADDR      = {32'h0000_0208, 32'h0000_0204,
                                               32'h0000_0200};

  localparam logic [7:0]          DATA_RST = 8'h00;
  localparam logic [2:0][15:0]    FC_RST   = {16'hAAAA, 16'h0000, 16'h0000};

  localparam logic [1:0] FN_OTHER = 2'h0;
  localparam logic [1:0] FN_OUT   = 2'h1;
  localparam logic [1:0] FN_IN_PU = 2'h2;
  localparam logic [1:0] FN_IN    = 2'h3;

  // Port D pins 4 and 6 are input only
  localparam logic [7:0] PD_DRIVE_MASK = 8'hAF;

  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic        HRESP_OKAY    = 1'h0;
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
  localparam logic [23:0] RD_PAD8       = 24'h00_0000;
  localparam logic [15:0] RD_PAD16      = 16'h0000;

endpackage : gpd_pkg

// File: logic/gpd_sync.sv
// Two-stage synchroniser for one byte of pin levels.
// Assumes pins change asynchronously to hclk; q lags d by two edges.
`timescale 1ns/1ps
module gpd_sync (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);

  logic [7:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= gpd_pkg::DATA_RST;
      q      <= gpd_pkg::DATA_RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : gpd_sync

// File: logic/gpd_port_regs.sv
// Data registers and pin muxing for byte-wide ports A, B and C, plus
// the pin split of port D, behind an AHB-Lite slave.
// Assumes hresetn is the power-on reset; no other reset reaches here.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module gpd_port_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [7:0]  pin_a_in,
  output logic      [7:0]  pin_a_out,
  output logic      [7:0]  pin_a_oe,
  output logic      [7:0]  pin_a_pull_en,
  input  wire logic [7:0]  periph_a_out,
  input  wire logic [7:0]  periph_a_oe,
  input  wire logic [7:0]  pin_b_in,
  output logic      [7:0]  pin_b_out,
  output logic      [7:0]  pin_b_oe,
  output logic      [7:0]  pin_b_pull_en,
  input  wire logic [7:0]  periph_b_out,
  input  wire logic [7:0]  periph_b_oe,
  input  wire logic [7:0]  pin_c_in,
  output logic      [7:0]  pin_c_out,
  output logic      [7:0]  pin_c_oe,
  output logic      [7:0]  pin_c_pull_en,
  input  wire logic [7:0]  periph_c_out,
  input  wire logic [7:0]  periph_c_oe,
  input  wire logic [7:0]  periph_d_out,
  input  wire logic [7:0]  periph_d_oe,
  output logic      [7:0]  pin_d_out,
  output logic      [7:0]  pin_d_oe
);

  logic [2:0][7:0]  data_r;
  logic [2:0][7:0]  data_nxt;
  logic [2:0][15:0] fc_r;
  logic [2:0][15:0] fc_nxt;
  logic [2:0][7:0]  pin_out_r;
  logic [2:0][7:0]  pin_oe_r;
  logic [2:0][7:0]  pull_r;
  logic [2:0]       wr_dhit_r;
  logic [2:0]       wr_fhit_r;
  logic [31:0]      hrdata_r;
  logic [7:0]       pd_out_r;
  logic [7:0]       pd_oe_r;

  wire  [2:0][7:0]  pin_in_w  = {pin_c_in, pin_b_in, pin_a_in};
  wire  [2:0][7:0]  per_out_w = {periph_c_out, periph_b_out, periph_a_out};
  wire  [2:0][7:0]  per_oe_w  = {periph_c_oe, periph_b_oe, periph_a_oe};
  logic [2:0][7:0]  sync_q;

  // Current setting drives the pins; the pending one steers reads
  logic [2:0][7:0]  out_m;
  logic [2:0][7:0]  oth_m;
  logic [2:0][7:0]  pu_m;
  logic [2:0][7:0]  out_nm;
  logic [2:0][7:0]  in_nm;
  logic [2:0][31:0] rd_dpart;
  logic [2:0][31:0] rd_fpart;
  logic [2:0]       hit_d;
  logic [2:0]       hit_f;
  logic [2:0]       hit_alt;
  logic [2:0][7:0]  rd_byte;

  wire         acc_w   = hsel & hready & htrans[1];
  wire  [29:0] widx_w  = haddr[31:gpd_pkg::ALSB];
  wire  [31:0] rd_word = rd_dpart[0] | rd_dpart[1] | rd_dpart[2]
                       | rd_fpart[0] | rd_fpart[1] | rd_fpart[2];

  genvar p;
  genvar n;
  generate
    for (p = 0; p < gpd_pkg::NPORT; p++) begin : g_port
      gpd_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (pin_in_w[p]),
        .q       (sync_q[p])
      );

      // Main and alternate index both select the same register
      assign hit_alt[p] = widx_w == gpd_pkg::DATA_ALT_IDX[p][29:0];
      assign hit_d[p]   = acc_w & (hit_alt[p]
                        | (widx_w == gpd_pkg::DATA_IDX[p][29:0]));
      assign hit_f[p]   = acc_w & (widx_w == gpd_pkg::FC_ADDR[p][31:2]);

      // Pending write folded in so a read right after a write sees it
      assign data_nxt[p] = wr_dhit_r[p] ? hwdata[7:0] : data_r[p];
      assign fc_nxt[p]   = wr_fhit_r[p] ? hwdata[15:0] : fc_r[p];

      for (n = 0; n < gpd_pkg::PW; n++) begin : g_bit
        wire [1:0] fn_w  = fc_r[p][2*n+1 -: 2];
        wire [1:0] fnn_w = fc_nxt[p][2*n+1 -: 2];
        assign out_m[p][n]  = fn_w == gpd_pkg::FN_OUT;
        assign oth_m[p][n]  = fn_w == gpd_pkg::FN_OTHER;
        assign pu_m[p][n]   = fn_w == gpd_pkg::FN_IN_PU;
        assign out_nm[p][n] = fnn_w == gpd_pkg::FN_OUT;
        assign in_nm[p][n]  = fnn_w[1];
      end

      // Input pins read the pin; all others read the stored bit
      assign rd_byte[p]  = (in_nm[p] & sync_q[p])
                         | (~in_nm[p] & data_nxt[p]);
      assign rd_dpart[p] = (hit_d[p] & ~hwrite)
                         ? {gpd_pkg::RD_PAD8, rd_byte[p]} : gpd_pkg::RD_ZERO;
      assign rd_fpart[p] = (hit_f[p] & ~hwrite)
                         ? {gpd_pkg::RD_PAD16, fc_nxt[p]} : gpd_pkg::RD_ZERO;
    end
  endgenerate

  // Only power-on reset clears the data; no other reset is wired in
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= {gpd_pkg::NPORT{gpd_pkg::DATA_RST}};
      fc_r   <= gpd_pkg::FC_RST;
    end else begin
      data_r <= data_nxt;
      fc_r   <= fc_nxt;
    end
  end

  // Address phase capture; slave never waits, so data phase is one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dhit_r <= 3'h0;
      wr_fhit_r <= 3'h0;
      hrdata_r  <= gpd_pkg::RD_ZERO;
    end else begin
      wr_dhit_r <= hwrite ? hit_d : 3'h0;
      wr_fhit_r <= hwrite ? hit_f : 3'h0;
      hrdata_r  <= rd_word;
    end
  end

  // Pins driven one cycle after the setting or data that steers them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_r <= '0;
      pin_oe_r  <= '0;
      pull_r    <= '0;
    end else begin
      for (int i = 0; i < gpd_pkg::NPORT; i++) begin
        pin_out_r[i] <= (out_m[i] & data_r[i])
                      | (oth_m[i] & per_out_w[i]);
        pin_oe_r[i]  <= out_m[i] | (oth_m[i] & per_oe_w[i]);
        pull_r[i]    <= pu_m[i];
      end
    end
  end

  // Port D: input-only pins can never be driven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_out_r <= gpd_pkg::DATA_RST;
      pd_oe_r  <= gpd_pkg::DATA_RST;
    end else begin
      pd_out_r <= periph_d_out & gpd_pkg::PD_DRIVE_MASK;
      pd_oe_r  <= periph_d_oe & gpd_pkg::PD_DRIVE_MASK;
    end
  end

  // Zero-wait slave; response always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= gpd_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= gpd_pkg::HRESP_OKAY;
    end
  end

  assign hrdata        = hrdata_r;
  assign pin_a_out     = pin_out_r[0];
  assign pin_a_oe      = pin_oe_r[0];
  assign pin_a_pull_en = pull_r[0];
  assign pin_b_out     = pin_out_r[1];
  assign pin_b_oe      = pin_oe_r[1];
  assign pin_b_pull_en = pull_r[1];
  assign pin_c_out     = pin_out_r[2];
  assign pin_c_oe      = pin_oe_r[2];
  assign pin_c_pull_en = pull_r[2];
  assign pin_d_out     = pd_out_r;
  assign pin_d_oe      = pd_oe_r;

  // Checks, port A standing in for the identical B and C lanes; port C reset and port D split checked directly
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Release edge skipped: flops still sit in reset on that edge

  wire rd_a_w  = hit_d[0] & ~hwrite;
  wire wr_a_w  = hit_d[0] & hwrite;
  wire alt_a_w = wr_a_w & hit_alt[0];

  out_drive_a: assert property (
    hresetn |=> ((pin_a_out ^ $past(data_r[0])) & $past(out_m[0])) == 8'h00
        && (pin_a_oe & $past(out_m[0])) == $past(out_m[0]))
    else $error("output pin does not follow stored bit");

  rd_output_a: assert property (
    rd_a_w |=> ((hrdata[7:0] ^ $past(data_nxt[0])) & $past(out_nm[0])) == 8'h00)
    else $error("read of output pin not the stored bit");

  rd_input_a: assert property (
    rd_a_w |=> ((hrdata[7:0] ^ $past(sync_q[0])) & $past(in_nm[0])) == 8'h00
               && hrdata[31:8] == gpd_pkg::RD_PAD8)
    else $error("read of input pin not the pin level");

  wr_store_a: assert property (
    wr_a_w |=> ##1 data_r[0] == $past(hwdata[7:0])
               && (pin_a_oe & ~$past(out_m[0]) & ~$past(oth_m[0])) == 8'h00)
    else $error("write not stored or moved an input pin");

  pull_en_a: assert property (
    hresetn |=> pin_a_pull_en == $past(pu_m[0])
        && (pin_a_pull_en & pin_a_oe) == 8'h00)
    else $error("pull-up not tied to setting 10");

  other_func_a: assert property (
    hresetn |=> ((pin_a_out ^ $past(periph_a_out)) & $past(oth_m[0])) == 8'h00
        && ((pin_a_oe ^ $past(periph_a_oe)) & $past(oth_m[0])) == 8'h00)
    else $error("peripheral does not own its pin");

  data_reset_a: assert property (
    @(posedge hclk) $rose(hresetn) |-> data_r == '0 && pin_a_oe == 8'h00)
    else $error("data not cleared by reset");

  pc_default_a: assert property (
    @(posedge hclk) $rose(hresetn) |-> fc_r[2] == gpd_pkg::FC_RST[2]
                                       ##1 pin_c_pull_en == 8'hFF)
    else $error("port C not input with pull-up after reset");

  alt_decode_a: assert property (
    alt_a_w |=> ##1 data_r[0] == $past(hwdata[7:0]))
    else $error("alternate address did not reach port A");

  pd_split_a: assert property (
    hresetn |-> (pin_d_oe & ~gpd_pkg::PD_DRIVE_MASK) == 8'h00
                ##1 pin_d_oe == ($past(periph_d_oe) & gpd_pkg::PD_DRIVE_MASK))
    else $error("input-only port D pin driven");

  sync_lag_a: assert property (
    hresetn |-> ##2 sync_q[0] == $past(pin_a_in, 2))
    else $error("pin level not two stages late");

endmodule : gpd_port_regs

// File: tb/gpd_pin_model.sv
// Board-side model of one byte-wide port: the level each pin line settles to.
// Assumes device drive wins; lines nobody drives or pulls keep changing.
`timescale 1ns/1ps
module gpd_pin_model (
  input  wire logic       hclk,
  input  wire logic [7:0] drv_out,
  input  wire logic [7:0] drv_oe,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_lvl
);
  logic [7:0] flt_r = 8'h5A;
  // Toggles so a floating line never passes for a settled value
  always @(posedge hclk) flt_r <= ~flt_r;
  assign pin_lvl = (drv_oe & drv_out)
                 | (~drv_oe & ext_en & ext_val)
                 | (~drv_oe & ~ext_en & (pull_en | flt_r));
endmodule : gpd_pin_model

// File: tb/eight_bit_io_port_data_regs_tb.sv
// Self-checking bench for the port data block: random settings and data.
// Assumes gpd_pin_model on each port and this bench as sole bus master.
`timescale 1ns/1ps
module eight_bit_io_port_data_regs_tb;
  logic             hclk, hresetn, hsel, hwrite;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, rd;
  wire logic        hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [2:0][7:0] p_out, p_oe, p_pu, p_in;
  wire logic [7:0]  pd_out, pd_oe;
  logic [2:0][7:0]  ext_v, ext_e, per_o, per_e, st;
  logic [2:0][15:0] fcm;
  logic [7:0]       pdo, pde;
  int               n_mismatch, compares;

  gpd_port_regs u_gpd_port_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_a_in(p_in[0]), .pin_a_out(p_out[0]), .pin_a_oe(p_oe[0]), .pin_a_pull_en(p_pu[0]),
    .periph_a_out(per_o[0]), .periph_a_oe(per_e[0]),
    .pin_b_in(p_in[1]), .pin_b_out(p_out[1]), .pin_b_oe(p_oe[1]), .pin_b_pull_en(p_pu[1]),
    .periph_b_out(per_o[1]), .periph_b_oe(per_e[1]),
    .pin_c_in(p_in[2]), .pin_c_out(p_out[2]), .pin_c_oe(p_oe[2]), .pin_c_pull_en(p_pu[2]),
    .periph_c_out(per_o[2]), .periph_c_oe(per_e[2]),
    .periph_d_out(pdo), .periph_d_oe(pde), .pin_d_out(pd_out), .pin_d_oe(pd_oe));

  for (genvar g = 0; g < 3; g++) begin : g_pin
    gpd_pin_model u_gpd_pin_model (.hclk(hclk), .drv_out(p_out[g]), .drv_oe(p_oe[g]),
      .pull_en(p_pu[g]), .ext_val(ext_v[g]), .ext_en(ext_e[g]), .pin_lvl(p_in[g]));
  end

  // k: 0 read, 1 oe, 2 out, 3 pull, 4 mask of pins not in input
  function automatic logic [7:0] f_exp(input int k, input int p);
    logic [7:0] r;
    logic [1:0] m;
    for (int i = 0; i < 8; i++) begin
      m = fcm[p][2*i+:2];
      case (k)
        0: r[i] = m[1] ? (ext_e[p][i] ? ext_v[p][i] : 1'b1) : st[p][i];
        1: r[i] = (m == gpd_pkg::FN_OUT) | ((m == gpd_pkg::FN_OTHER) & per_e[p][i]);
        2: r[i] = (m == gpd_pkg::FN_OUT) ? st[p][i] : per_o[p][i] & ~m[1];
        3: r[i] = (m == gpd_pkg::FN_IN_PU);
        default: r[i] = ~m[1];
      endcase
    end
    return r;
  endfunction : f_exp

  function automatic logic [31:0] f_adr(input int p, input bit alt);
    return alt ? {gpd_pkg::DATA_ALT_IDX[p][29:0], 2'h0} : {gpd_pkg::DATA_IDX[p][29:0], 2'h0};
  endfunction : f_adr

  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= gpd_pkg::HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    cmp("hresp", gpd_pkg::HRESP_OKAY, hresp);
  endtask : ahb

  // Board drives only input pins; pulled pins are sometimes left to the pull-up
  task automatic stim(input int p);
    ext_v[p] <= 8'($urandom);
    ext_e[p] <= ~f_exp(4, p) & (8'($urandom) | ~f_exp(3, p));
    per_o[p] <= 8'($urandom);
    per_e[p] <= 8'($urandom);
    pdo      <= 8'($urandom);
    pde      <= 8'($urandom);
  endtask : stim

  task automatic chk(input int p);
    repeat (5) @(posedge hclk);
    cmp("oe", f_exp(1, p), p_oe[p]);
    cmp("out", f_exp(2, p), p_out[p] & f_exp(4, p));
    cmp("pull", f_exp(3, p), p_pu[p]);
    cmp("pd_oe", pde & gpd_pkg::PD_DRIVE_MASK, pd_oe);
    cmp("pd_out", pdo & gpd_pkg::PD_DRIVE_MASK, pd_out);
    ahb(1'b0, f_adr(p, $urandom_range(1, 0)), 32'h0);
    cmp("data", {gpd_pkg::RD_PAD8, f_exp(0, p)}, rd);
  endtask : chk

  task automatic close_out();
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end

  initial begin : main
    int p;
    {hresetn, hsel, hwrite, haddr, hwdata} = '0;
    htrans = gpd_pkg::HTRANS_IDLE;
    hsize  = 3'h2;
    {ext_v, ext_e, per_o, per_e, pdo, pde} = '0;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(32'h8E7D));
    // Second pass is a mid-run power-on reset after random traffic
    for (int r = 0; r < 2; r++) begin
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      st = '0;
      fcm = gpd_pkg::FC_RST;
      @(posedge hclk);
      for (int q = 0; q < 3; q++) begin
        stim(q);
        chk(q);
      end
      if (r == 0) begin
        for (int n = 0; n < 40; n++) begin
          p = $urandom_range(2, 0);
          fcm[p] = 16'($urandom);
          ahb(1'b1, gpd_pkg::FC_ADDR[p], {16'h0, fcm[p]});
          if ($urandom_range(1, 0) == 1) begin
            st[p] = 8'($urandom);
            ahb(1'b1, f_adr(p, $urandom_range(1, 0)), {24'h0, st[p]});
          end
          stim(p);
          chk(p);
        end
        ahb(1'b1, 32'h1000_0484, 32'hFFFF_FFFF);
        ahb(1'b0, 32'h1000_0484, 32'h0);
        cmp("unmapped", gpd_pkg::RD_ZERO, rd);
        for (int q = 0; q < 3; q++) chk(q);
      end
    end
    close_out();
  end
endmodule : eight_bit_io_port_data_regs_tb
